// [esn_bus_ctrl.sv]
// Purpose: device side of the shared external static, I/O and NAND bus
// Assumes: one request at a time from the internal side; wait and ready/busy pins synchronised here
// Notes: cycle counts come from ports since the control registers lie elsewhere
// Operation
// RL1: Drive and read a 16-bit bidirectional shared data bus.
// RL2: Support 8-bit static and I/O cycles on the low byte lane only.
// RL3: Only one kind of access drives the shared data bus at once.
// RL4: Three I/O banks, each decoding at most 16 kilobytes.
// RL5: One active-low select per I/O bank, only the accessed one asserted.
// RL6: Two static banks with own selects; address mapped under control settings.
// RL7: Static bank 0 may be the boot source for boot fetches.
// RL8: Low wait input stretches the current static or I/O access.
// RL9: Active-low output enable asserted during static and I/O reads.
// RL10: Upper byte write enable only when writing bits 15 to 8.
// RL11: Lower write enable for bits 7 to 0; whole-bus strobe in 8-bit mode.
// RL12: Raise command latch enable while a NAND command byte is driven.
// RL13: Raise address latch enable while NAND address bytes are driven.
// RL14: Two active-low NAND chip enables; only the addressed one asserted.
// RL15: NAND bank 0 may be chosen as boot device instead.
// RL16: Drive a 24-bit address bus shared by static and I/O devices.
// RL17: NAND reads strobe low read enable, writes low write enable.
// RL18: NAND bank holds ready/busy low while busy; wait for high first.
// RL19: At most one chip select among all banks at any time.
`include "esn_cfg.svh"
`timescale 1ns/1ns
`default_nettype none
module esn_bus_ctrl #(
	parameter int DATA_W = `ESN_DATA_W,
	parameter int ADDR_W = `ESN_ADDR_W
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Configuration
	input wire logic bus_8bit,
	input wire logic boot_mode,
	input wire logic boot_from_nand,
	input wire logic [`ESN_CYC_W-1:0] access_cycles,
	// Internal request side
	input wire logic req_valid,
	input wire esn_pkg::esn_req_t req,
	output logic req_ready,
	output logic rsp_valid,
	output logic [DATA_W-1:0] rsp_rdata,
	// Shared data bus
	input wire logic [DATA_W-1:0] shared_data_bus_in,
	output logic [DATA_W-1:0] shared_data_bus_out,
	output logic shared_data_bus_oe_n,
	// Static and I/O pins
	output logic [ADDR_W-1:0] static_address_bus,
	output logic [`ESN_IO_BANKS-1:0] io_bank_selects_n,
	output logic static_bank1_select_n,
	output logic static_bank0_select_n,
	output logic static_output_enable_n,
	output logic upper_byte_write_n,
	output logic lower_byte_write_n,
	input wire logic ext_wait_n,
	// NAND pins
	output logic flash_command_latch,
	output logic flash_address_latch,
	output logic flash_bank1_enable_n,
	output logic flash_bank0_enable_n,
	output logic flash_read_strobe_n,
	output logic flash_write_strobe_n,
	input wire logic [`ESN_NF_BANKS-1:0] flash_ready_busy_n
);
	//----------------------------------------
	// State
	//----------------------------------------
	typedef enum logic [1:0] {
		ESN_IDLE = 2'b00,
		ESN_BUSY_WAIT = 2'b01,
		ESN_STROBE = 2'b10,
		ESN_DONE = 2'b11
	} esn_state_t;
	esn_state_t state_ff;
	esn_pkg::esn_req_t cur_ff;
	logic [`ESN_CYC_W-1:0] cnt_ff;
	logic wait_s1_ff;
	logic wait_s2_ff;
	logic [`ESN_NF_BANKS-1:0] rb_s1_ff;
	logic [`ESN_NF_BANKS-1:0] rb_s2_ff;
	logic boot_ff;
	logic boot_nand_ff;
	logic [DATA_W-1:0] rdata_ff;
	logic rsp_ff;

	// Wait and ready/busy pins from outside pass two flops first
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			wait_s1_ff <= 1'b1;
			wait_s2_ff <= 1'b1;
			rb_s1_ff <= '1;
			rb_s2_ff <= '1;
		end else begin
			wait_s1_ff <= ext_wait_n;
			wait_s2_ff <= wait_s1_ff;
			rb_s1_ff <= flash_ready_busy_n;
			rb_s2_ff <= rb_s1_ff;
		end
	end

	// Boot strap followed every edge after release, held once boot_mode drops
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			boot_ff <= 1'b1;
			boot_nand_ff <= 1'b0;
		end else begin
			if (boot_ff)
				boot_nand_ff <= boot_from_nand;
			if (!boot_mode)
				boot_ff <= 1'b0;
		end
	end

	//----------------------------------------
	// Bank decode
	//----------------------------------------
	function automatic logic [1:0] eff_bank(input esn_pkg::esn_req_t r, input logic bt,
			input logic bn);
		eff_bank = r.bank;
		if (bt && r.target == esn_pkg::ESN_T_STATIC && bn)
			eff_bank = 2'h0; // RL15
		else if (bt && r.target != esn_pkg::ESN_T_IO)
			eff_bank = 2'h0; // RL7
	endfunction : eff_bank

	function automatic esn_pkg::esn_target_t eff_target(input esn_pkg::esn_req_t r,
			input logic bt, input logic bn);
		eff_target = r.target;
		if (bt && r.target == esn_pkg::ESN_T_STATIC && bn)
			eff_target = esn_pkg::ESN_T_NAND; // RL15
	endfunction : eff_target

	logic nxt_take;
	logic [1:0] nxt_bank;
	esn_pkg::esn_target_t nxt_tgt;
	always_comb begin
		nxt_take = (state_ff == ESN_IDLE) && req_valid;
		nxt_bank = eff_bank(req, boot_ff, boot_nand_ff);
		nxt_tgt = eff_target(req, boot_ff, boot_nand_ff);
	end

	//----------------------------------------
	// Sequencer
	//----------------------------------------
	logic is_nand;
	logic st_8bit;
	always_comb begin
		is_nand = (cur_ff.target == esn_pkg::ESN_T_NAND);
		st_8bit = bus_8bit && !is_nand;
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state_ff <= ESN_IDLE;
			cur_ff <= '0;
			cnt_ff <= '0;
		end else begin
			unique case (state_ff)
				ESN_IDLE: begin
					if (nxt_take) begin
						cur_ff <= req;
						cur_ff.target <= nxt_tgt;
						cur_ff.bank <= nxt_bank;
						if (nxt_tgt == esn_pkg::ESN_T_IO)
							cur_ff.addr <= {{(`ESN_ADDR_W-`ESN_IO_SPAN_W){1'b0}},
								req.addr[`ESN_IO_SPAN_W-1:0]}; // RL4
						cnt_ff <= access_cycles;
						state_ff <= (nxt_tgt == esn_pkg::ESN_T_NAND) ? ESN_BUSY_WAIT : ESN_STROBE;
					end
				end
				ESN_BUSY_WAIT: begin
					if (rb_s2_ff[cur_ff.bank[0]]) // RL18
						state_ff <= ESN_STROBE;
				end
				ESN_STROBE: begin
					if (cnt_ff != '0)
						cnt_ff <= cnt_ff - 1'b1;
					else if (is_nand || wait_s2_ff) // RL8
						state_ff <= ESN_DONE;
				end
				ESN_DONE: state_ff <= ESN_IDLE;
			endcase
		end
	end

	//----------------------------------------
	// Pin drivers, all registered
	//----------------------------------------
	logic act;
	always_comb act = (state_ff == ESN_STROBE) || (state_ff == ESN_BUSY_WAIT);

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			io_bank_selects_n <= '1;
			static_bank0_select_n <= 1'b1;
			static_bank1_select_n <= 1'b1;
			flash_bank0_enable_n <= 1'b1;
			flash_bank1_enable_n <= 1'b1;
			static_address_bus <= '0;
		end else begin
			// One decoded target only, so selects never overlap
			for (int i = 0; i < `ESN_IO_BANKS; i++)
				io_bank_selects_n[i] <= !(act && cur_ff.target == esn_pkg::ESN_T_IO &&
					cur_ff.bank == 2'(i)); // RL5 RL19
			static_bank0_select_n <= !(act && cur_ff.target == esn_pkg::ESN_T_STATIC &&
				cur_ff.bank == 2'h0); // RL6 RL19
			static_bank1_select_n <= !(act && cur_ff.target == esn_pkg::ESN_T_STATIC &&
				cur_ff.bank == 2'h1); // RL6
			flash_bank0_enable_n <= !(act && is_nand && cur_ff.bank == 2'h0); // RL14
			flash_bank1_enable_n <= !(act && is_nand && cur_ff.bank == 2'h1); // RL14
			static_address_bus <= is_nand ? '0 : cur_ff.addr; // RL16
		end
	end

	logic strobe;
	always_comb strobe = (state_ff == ESN_STROBE);

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			static_output_enable_n <= 1'b1;
			upper_byte_write_n <= 1'b1;
			lower_byte_write_n <= 1'b1;
			flash_command_latch <= 1'b0;
			flash_address_latch <= 1'b0;
			flash_read_strobe_n <= 1'b1;
			flash_write_strobe_n <= 1'b1;
		end else begin
			static_output_enable_n <= !(strobe && !is_nand && !cur_ff.write); // RL9
			upper_byte_write_n <= !(strobe && !is_nand && cur_ff.write && !st_8bit &&
				cur_ff.byte_en[1]); // RL10 RL2
			lower_byte_write_n <= !(strobe && !is_nand && cur_ff.write &&
				(st_8bit || cur_ff.byte_en[0])); // RL11
			flash_command_latch <= strobe && is_nand &&
				cur_ff.nphase == esn_pkg::ESN_N_CMD; // RL12
			flash_address_latch <= strobe && is_nand &&
				cur_ff.nphase == esn_pkg::ESN_N_ADDR; // RL13
			flash_read_strobe_n <= !(strobe && is_nand && !cur_ff.write); // RL17
			flash_write_strobe_n <= !(strobe && is_nand && cur_ff.write); // RL17
		end
	end

	// Data lanes: one owner per access, low lane only for byte-wide buses
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			shared_data_bus_out <= '0;
			shared_data_bus_oe_n <= 1'b1;
		end else begin
			shared_data_bus_oe_n <= !(strobe && cur_ff.write); // RL1 RL3
			shared_data_bus_out <= (is_nand || st_8bit) ?
				{8'h00, cur_ff.wdata[7:0]} : cur_ff.wdata; // RL2
		end
	end

	// Read capture in the done cycle, one after the last strobe; pins are stable by then
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rdata_ff <= '0;
			rsp_ff <= 1'b0;
			req_ready <= 1'b0;
		end else begin
			rsp_ff <= 1'b0;
			if (state_ff == ESN_DONE) begin
				rsp_ff <= 1'b1;
				if (!cur_ff.write)
					rdata_ff <= (is_nand || st_8bit) ?
						{8'h00, shared_data_bus_in[7:0]} : shared_data_bus_in; // RL1 RL2
			end
			req_ready <= (state_ff == ESN_IDLE) && !nxt_take;
		end
	end
	always_comb begin
		rsp_valid = rsp_ff;
		rsp_rdata = rdata_ff;
	end
endmodule : esn_bus_ctrl
`default_nettype wire

// [esn_bus_ctrl_sva.sv]
// Purpose: pin relations of the shared external bus controller
// Assumes: sees only the controller's ports
// Notes: strobes other than the unwatched lower write enable may only show under a select of the matching kind
`timescale 1ns/1ns
`default_nettype none
module esn_bus_ctrl_sva (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Watched pins
	input wire logic bus_8bit,
	input wire logic ext_wait_n,
	input wire logic shared_data_bus_oe_n,
	input wire logic [2:0] io_bank_selects_n,
	input wire logic static_bank1_select_n,
	input wire logic static_bank0_select_n,
	input wire logic static_output_enable_n,
	input wire logic upper_byte_write_n,
	input wire logic flash_command_latch,
	input wire logic flash_address_latch,
	input wire logic flash_bank1_enable_n,
	input wire logic flash_bank0_enable_n,
	input wire logic flash_read_strobe_n,
	input wire logic flash_write_strobe_n
);
	wire logic [6:0] sel_on = ~{io_bank_selects_n, static_bank1_select_n,
		static_bank0_select_n, flash_bank1_enable_n, flash_bank0_enable_n};
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	sequence s_flash_drive;
		(|sel_on[1:0]) && !shared_data_bus_oe_n;
	endsequence
	// Five cycles covers the two-flop sync plus one decision cycle
	sequence s_held_wait;
		((|sel_on[6:2]) && !ext_wait_n) [*5];
	endsequence
	a_one_select: assert property ($countones(sel_on) <= 1)
		else $error("two selects low");
	a_oe_selected: assert property (
		!static_output_enable_n |-> (|sel_on[6:2]) && shared_data_bus_oe_n)
		else $error("read enable without static select");
	a_flash_read: assert property (
		!flash_read_strobe_n |-> (|sel_on[1:0]) && shared_data_bus_oe_n && flash_write_strobe_n)
		else $error("bad flash read strobe");
	a_flash_write: assert property (!flash_write_strobe_n |-> s_flash_drive)
		else $error("bad flash write strobe");
	a_upper_lane: assert property (
		!upper_byte_write_n |-> !bus_8bit && (|sel_on[6:2]) && !shared_data_bus_oe_n)
		else $error("bad upper write");
	a_cmd_latch: assert property (
		flash_command_latch |-> !flash_address_latch ##0 s_flash_drive)
		else $error("bad command latch");
	a_addr_latch: assert property (
		flash_address_latch |-> !flash_command_latch ##0 s_flash_drive)
		else $error("bad address latch");
	a_wait_stretch: assert property (s_held_wait |=> (|sel_on[6:2]))
		else $error("access ended during wait");
endmodule : esn_bus_ctrl_sva
`default_nettype wire

// [esn_bus_ctrl_tb.sv]
// Purpose: self-checking bench for the shared external bus controller
// Assumes: inputs change 1 ns after the rising edge; one request at a time
// Notes: the pin trace is sticky per access, so a one-cycle glitch still shows
`timescale 1ns/1ns
`default_nettype none
module esn_bus_ctrl_tb;
	logic clk = 1'b0, rstn = 1'b0, b8 = 1'b0, bm = 1'b1, bn = 1'b0, slow = 1'b0, busy = 1'b0;
	logic req_valid = 1'b0, req_ready, rsp_valid, ow_n, oe_n, uw_n, lw_n, cle, ale, w_n;
	logic s1_n, s0_n, f1_n, f0_n, fr_n, fw_n;
	// Long enough that a wait raised at select time is seen through the sync before count end
	logic [3:0] cyc = 4'h4;
	logic [2:0] io_n;
	logic [15:0] rd, dout, din, wcap;
	logic [23:0] sa, acap;
	logic [13:0] seen;
	esn_pkg::esn_req_t req = '0;
	int failures = 0, num_checks = 0;
	always #4 clk = ~clk;
	always @(posedge clk) begin
		seen <= seen | ~{io_n, s1_n, s0_n, f1_n, f0_n, oe_n, uw_n, lw_n, fr_n, fw_n, ~cle, ~ale};
		if (!ow_n) wcap <= dout;
		if (!(&io_n)) acap <= sa;
	end
	esn_bus_ctrl esn_bus_ctrl_inst (.clk, .rstn, .bus_8bit(b8), .boot_mode(bm), .boot_from_nand(bn),
		.access_cycles(cyc), .req_valid, .req, .req_ready, .rsp_valid, .rsp_rdata(rd),
		.shared_data_bus_in(din), .shared_data_bus_out(dout), .shared_data_bus_oe_n(ow_n),
		.static_address_bus(sa), .io_bank_selects_n(io_n), .static_bank1_select_n(s1_n),
		.static_bank0_select_n(s0_n), .static_output_enable_n(oe_n), .upper_byte_write_n(uw_n),
		.lower_byte_write_n(lw_n), .ext_wait_n(w_n), .flash_command_latch(cle),
		.flash_address_latch(ale), .flash_bank1_enable_n(f1_n), .flash_bank0_enable_n(f0_n),
		.flash_read_strobe_n(fr_n), .flash_write_strobe_n(fw_n), .flash_ready_busy_n({1'b1, ~busy}));
	esn_ext_dev esn_ext_dev_inst (.clk, .sel_n(&{io_n, s1_n, s0_n}), .rd_n(oe_n & fr_n),
		.dq(din), .wait_n(w_n), .slow);
	task automatic tick;
		@(posedge clk);
		#1;
	endtask : tick
	task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string what);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	// Request is raised only while ready shows idle, so it is taken exactly once
	task automatic acc(input logic [1:0] t, p, input logic w, input logic [1:0] b, be, output int n);
		n = 0;
		while (req_ready !== 1'b1) tick();
		seen = '0;
		req = '{esn_pkg::esn_target_t'(t), esn_pkg::esn_nphase_t'(p), w, b, 24'h00a5c3, 16'hc35a, be};
		req_valid = 1'b1;
		tick();
		req_valid = 1'b0;
		while (rsp_valid !== 1'b1 && n < 300) begin
			tick();
			n++;
		end
		chk(n < 300, 1'b1, "response time");
		tick();
	endtask : acc
	task automatic t_boot;
		int n;
		acc(2'h0, 2'h2, 1'b0, 2'h1, 2'h3, n);
		chk(seen, 14'h0240, "boot static");
		bn = 1'b1;
		// The strap is caught one edge late, so let an edge pass before the request
		tick();
		acc(2'h0, 2'h2, 1'b0, 2'h1, 2'h3, n);
		chk(seen, 14'h0088, "boot flash");
		bn = 1'b0;
		bm = 1'b0;
		tick();
		$display("t_boot done");
	endtask : t_boot
	task automatic t_static;
		int n;
		acc(2'h0, 2'h2, 1'b0, 2'h1, 2'h3, n);
		chk(seen, 14'h0440, "static read pins");
		chk(rd, 16'h5aa5, "static read data");
		acc(2'h0, 2'h2, 1'b1, 2'h0, 2'h3, n);
		chk(seen, 14'h0230, "static write pins");
		chk(wcap, 16'hc35a, "write data");
		acc(2'h0, 2'h2, 1'b1, 2'h1, 2'h2, n);
		chk(seen, 14'h0420, "upper only");
		b8 = 1'b1;
		acc(2'h0, 2'h2, 1'b1, 2'h0, 2'h3, n);
		chk(seen, 14'h0210, "byte write pins");
		chk(wcap[7:0], 8'h5a, "byte write data");
		b8 = 1'b0;
		$display("t_static done");
	endtask : t_static
	task automatic t_io;
		int n;
		for (int b = 0; b < 3; b++) begin
			acc(2'h1, 2'h2, 1'b0, b[1:0], 2'h3, n);
			chk(seen, 14'h0040 | (14'h0800 << b), "io select");
			chk(acap, 24'h0025c3, "io address");
		end
		$display("t_io done");
	endtask : t_io
	task automatic t_nand;
		int n;
		acc(2'h2, 2'h0, 1'b1, 2'h1, 2'h3, n);
		chk(seen, 14'h0106, "flash command");
		acc(2'h2, 2'h1, 1'b1, 2'h0, 2'h3, n);
		chk(seen, 14'h0085, "flash address");
		acc(2'h2, 2'h2, 1'b0, 2'h1, 2'h3, n);
		chk(seen, 14'h0108, "flash read");
		chk(rd[7:0], 8'ha5, "flash data");
		$display("t_nand done");
	endtask : t_nand
	task automatic t_wait;
		int n0, n1, n2;
		acc(2'h0, 2'h2, 1'b0, 2'h0, 2'h3, n0);
		slow = 1'b1;
		acc(2'h0, 2'h2, 1'b0, 2'h0, 2'h3, n1);
		slow = 1'b0;
		chk(n1 > n0 + 2, 1'b1, "wait stretch");
		cyc = 4'h2;
		acc(2'h0, 2'h2, 1'b0, 2'h0, 2'h3, n2);
		cyc = 4'h4;
		chk(n0 - n2 == 2, 1'b1, "cycle count");
		$display("t_wait done");
	endtask : t_wait
	task automatic t_busy;
		int n;
		busy = 1'b1;
		repeat (3) tick();
		fork
			acc(2'h2, 2'h2, 1'b0, 2'h0, 2'h3, n);
		join_none
		repeat (20) tick();
		// Chip enable must stand while busy, but no strobe may show
		chk(seen, 14'h0080, "busy hold");
		busy = 1'b0;
		wait fork;
		chk(seen, 14'h0088, "after busy");
		$display("t_busy done");
	endtask : t_busy
	task automatic close_out;
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : close_out
	initial begin
		repeat (12) tick();
		rstn = 1'b1;
		t_boot();
		t_static();
		t_io();
		t_nand();
		t_wait();
		t_busy();
		close_out();
	end
	initial begin
		#40000;
		failures++;
		close_out();
	end
endmodule : esn_bus_ctrl_tb
bind esn_bus_ctrl esn_bus_ctrl_sva esn_bus_ctrl_sva_inst (.clk, .rstn, .bus_8bit, .ext_wait_n,
	.shared_data_bus_oe_n, .io_bank_selects_n, .static_bank1_select_n, .static_bank0_select_n,
	.static_output_enable_n, .upper_byte_write_n, .flash_command_latch, .flash_address_latch,
	.flash_bank1_enable_n, .flash_bank0_enable_n, .flash_read_strobe_n, .flash_write_strobe_n);
`default_nettype wire

// [esn_cfg.svh]
// Purpose: constants for the external static/NAND bus controller
// Assumes: 125 MHz system clock
// Notes: timing counts are in clock cycles
`ifndef ESN_CFG_SVH
`define ESN_CFG_SVH
`define ESN_DATA_W 16
`define ESN_ADDR_W 24
`define ESN_IO_SPAN_W 14
`define ESN_CYC_W 4
`define ESN_IO_BANKS 3
`define ESN_ST_BANKS 2
`define ESN_NF_BANKS 2
`endif

// [esn_ext_dev.sv]
// Purpose: stand-in for the static memory or I/O device on the far side
// Assumes: one active-low select and one active-low read strobe
// Notes: an idle bus shows the inverse of read data, never a held value
`timescale 1ns/1ns
`default_nettype none
module esn_ext_dev (
	// Pins
	input wire logic clk,
	input wire logic sel_n,
	input wire logic rd_n,
	output logic [15:0] dq,
	output logic wait_n,
	// Bench control
	input wire logic slow
);
	logic [2:0] cnt_ff;
	// A slow device holds wait low for six cycles from its select
	assign wait_n = !(slow && !sel_n && cnt_ff != 3'h0);
	assign dq = rd_n ? 16'ha55a : 16'h5aa5;
	always_ff @(posedge clk) begin
		cnt_ff <= sel_n ? 3'h6 : cnt_ff - {2'h0, cnt_ff != 3'h0};
	end
endmodule : esn_ext_dev
`default_nettype wire

// [esn_pkg.sv]
// Purpose: types for the external static/NAND bus controller
// Assumes: esn_cfg.svh constants
// Notes: requests travel as a packed struct
`include "esn_cfg.svh"
package esn_pkg;
	typedef enum logic [1:0] {
		ESN_T_STATIC = 2'b00,
		ESN_T_IO = 2'b01,
		ESN_T_NAND = 2'b10
	} esn_target_t;
	typedef enum logic [1:0] {
		ESN_N_CMD = 2'b00,
		ESN_N_ADDR = 2'b01,
		ESN_N_DATA = 2'b10
	} esn_nphase_t;
	typedef struct packed {
		esn_target_t target;
		esn_nphase_t nphase;
		logic write;
		logic [1:0] bank;
		logic [`ESN_ADDR_W-1:0] addr;
		logic [`ESN_DATA_W-1:0] wdata;
		logic [1:0] byte_en;
	} esn_req_t;
endpackage : esn_pkg
